// *** psfp_dev_model.sv ***
// Behavioural device side of the peripheral port, the timing master.
`timescale 1ns/1ps
module psfp_dev_model (
    input wire logic run_in,
    input wire logic iom_in,
    input wire logic inv_in,
    input wire logic idle_in,
    input wire logic [95:0] tx_in,
    input wire logic pin_in,
    input wire logic oe_in,
    output logic clk_out,
    output logic fs_out,
    output logic sd_out,
    output logic [95:0] cap_out
);
    logic [95:0] frm;
    logic line;
    logic flt;
    // Free-running frames of 24 or 96 bits, 200 ns per bit.
    initial begin
        {clk_out, fs_out, sd_out, line, flt} = 5'h0;
        frm = '0;
        cap_out = '0;
        #13;
        forever begin
            if (!run_in) begin
                if (!flt) begin
                    {clk_out, fs_out, sd_out} = ~{clk_out, fs_out, sd_out};
                end
                flt = 1'b1;
                #100;
            end else begin
                flt = 1'b0;
                for (int i = 0; i < (iom_in ? 96 : 24) && run_in; i++) begin
                    clk_out = inv_in;
                    fs_out = !idle_in && i < 8;
                    sd_out = tx_in[95 - i];
                    #100;
                    clk_out = !inv_in;
                    line = oe_in ? pin_in : (iom_in ? 1'b1 : ~line);
                    frm[95 - i] = line;
                    #100;
                end
                cap_out = frm;
            end
        end
    end
endmodule

// *** psfp_host.sv ***
// Host end that follows the device's peripheral port clocks and exchanges frames.
//
// Behaviour
// - Sample on rising, change on falling; this host changes its output right after the rising edge.
// - Layer-1 uses subframe 0, never reverses.
// - Downstream uses subframes 0 and 1.
// - IOM-2 frame is three 32-bit subframes.
// - Two bearer slots of 64 kbit/s.
// - Two monitor channels with handshake bits.
// - One 16 kbit/s signaling channel.
// - Command fields four and six bits.
// - Two intercommunication slots of 64 kbit/s.
// - MSB first except signaling, LSB first.
// - Signaling channel shared through arbitration channel; this host has none and sends its signaling bits when subframe 0 is enabled.
// - Bearers are first two slots, d and e.
`timescale 1ns/1ps
module psfp_host
    import psfp_pkg::*;
#(
    parameter int LOSS_CYCLES = PSFP_LOSS_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic host_enable_in,
    input wire logic iom_mode_in,
    input wire logic clk_invert_in,
    input wire logic [95:0] tx_frame_in,
    input wire logic [1:0] tx_d_in,
    input wire logic [2:0] tx_sub_en_in,
    input wire logic bit_clock_in,
    input wire logic frame_sync_in,
    input wire logic dev_serial_out_in,
    output logic dev_serial_in_out,
    output logic dev_serial_in_oe_out,
    output logic [95:0] rx_frame_out,
    output logic rx_valid_out,
    output logic [7:0] rx_bearer_one_out,
    output logic [7:0] rx_bearer_two_out,
    output logic [7:0] rx_slot_f_out,
    output logic [3:0] rx_ci_first_out,
    output logic [5:0] rx_ci_second_out,
    output logic [1:0] rx_d_out,
    output logic [1:0] rx_monitor_transmit_handshake_out,
    output logic [1:0] rx_monitor_receive_handshake_out,
    output logic locked_out
);

    localparam logic [PSFP_LOSS_W-1:0] LOSS_LAST = PSFP_LOSS_W'(LOSS_CYCLES - 1);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [2:0] s1_next, s2_next, s3_next, filt_next;

    // Three stages per pin; a level is accepted once stages two and three agree.
    always_comb begin
        s1_next = {dev_serial_out_in, frame_sync_in, bit_clock_in};
        s2_next = s1_reg;
        s3_next = s2_reg;
        for (int i = 0; i < 3; i++) begin
            filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
        end
    end

    // Registers of the synchronisers.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
            filt_reg <= 3'h0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            filt_reg <= filt_next;
        end
    end

    // ==========================================================
    // Edge detection and frame handling
    // ==========================================================
    logic bclk_eff;
    logic bclk_rise;
    logic fs_start;
    logic [95:0] tx_vec;
    logic bclk_prev_reg, bclk_prev_next;
    logic fs_prev_reg, fs_prev_next;

    // The device may invert its bit clock, so the effective edge is chosen here.
    assign bclk_eff = filt_reg[0] ^ clk_invert_in;
    assign bclk_rise = bclk_eff & ~bclk_prev_reg;
    assign fs_start = filt_reg[1] & ~fs_prev_reg;

    psfp_state_t state_reg, state_next;
    logic [6:0] cnt_reg, cnt_next;
    logic [95:0] work_reg, work_next;
    logic [95:0] rx_frame_reg, rx_frame_next;
    logic rx_valid_reg, rx_valid_next;
    logic pin_reg, pin_next;
    logic oe_reg, oe_next;
    logic [PSFP_LOSS_W-1:0] loss_reg, loss_next;
    logic [6:0] idx;
    logic [6:0] last_idx;

    // Signaling bits travel least significant first, so they are swapped into place.
    always_comb begin
        tx_vec = tx_frame_in;
        if (iom_mode_in) begin
            tx_vec[PSFP_D_BIT0_POS] = tx_d_in[0];
            tx_vec[PSFP_D_BIT1_POS] = tx_d_in[1];
        end
    end

    // Bit counter, receive assembly, transmit drive and loss of clock supervision.
    always_comb begin
        state_next = state_reg;
        bclk_prev_next = bclk_eff;
        fs_prev_next = fs_prev_reg;
        cnt_next = cnt_reg;
        work_next = work_reg;
        rx_frame_next = rx_frame_reg;
        rx_valid_next = 1'b0;
        pin_next = pin_reg;
        oe_next = oe_reg;
        loss_next = loss_reg;
        idx = fs_start ? 7'h00 : cnt_reg;
        last_idx = iom_mode_in ? PSFP_IOM_LAST : PSFP_LEGACY_LAST;
        if (!host_enable_in) begin
            state_next = PSFP_HUNT;
            cnt_next = 7'h00;
            oe_next = 1'b0;
            loss_next = '0;
        end else if (bclk_rise) begin
            // Device output is stable at the rising edge.
            fs_prev_next = filt_reg[1];
            loss_next = '0;
            work_next[PSFP_FRAME_TOP - idx] = filt_reg[2];
            if (fs_start) begin
                state_next = PSFP_LOCKED;
            end
            if (idx == last_idx) begin
                cnt_next = 7'h00;
                if (state_reg == PSFP_LOCKED) begin
                    rx_frame_next = work_next;
                    rx_valid_next = 1'b1;
                end
            end else begin
                cnt_next = idx + 7'h01;
            end
            // The next bit goes out right after the rising edge. The pin synchronisers delay a falling edge
            // by about half a fast bit period, so waiting for it would miss the device's rising sample.
            unique case (state_next)
                PSFP_HUNT: begin
                    oe_next = 1'b0;
                end
                PSFP_LOCKED: begin
                    if (iom_mode_in) begin
                        pin_next = 1'b0;
                        oe_next = tx_sub_en_in[cnt_next[6:PSFP_SUB_LSB]]
                            & ~tx_vec[PSFP_FRAME_TOP - cnt_next];
                    end else begin
                        pin_next = tx_vec[PSFP_FRAME_TOP - cnt_next];
                        oe_next = 1'b1;
                    end
                end
            endcase
        end else if (loss_reg == LOSS_LAST) begin
            // A clock that stops, as in power-down, ends the lock.
            state_next = PSFP_HUNT;
            oe_next = 1'b0;
            loss_next = '0;
        end else begin
            loss_next = loss_reg + 1'b1;
        end
    end

    // Registers of the frame logic.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= PSFP_HUNT;
            bclk_prev_reg <= clk_invert_in; // Matches the cleared synchroniser, so no false edge follows reset.
            fs_prev_reg <= 1'b0;
            cnt_reg <= 7'h00;
            work_reg <= '0;
            rx_frame_reg <= '0;
            rx_valid_reg <= 1'b0;
            pin_reg <= 1'b1;
            oe_reg <= 1'b0;
            loss_reg <= '0;
        end else begin
            state_reg <= state_next;
            bclk_prev_reg <= bclk_prev_next;
            fs_prev_reg <= fs_prev_next;
            cnt_reg <= cnt_next;
            work_reg <= work_next;
            rx_frame_reg <= rx_frame_next;
            rx_valid_reg <= rx_valid_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            loss_reg <= loss_next;
        end
    end

    // ==========================================================
    // Output fields
    // ==========================================================
    // Received fields are slices of the last complete frame.
    assign rx_frame_out = rx_frame_reg;
    assign rx_valid_out = rx_valid_reg;
    assign rx_bearer_one_out = rx_frame_reg[PSFP_BEARER_ONE_MSB -: 8];
    assign rx_bearer_two_out = rx_frame_reg[PSFP_BEARER_TWO_MSB -: 8];
    assign rx_slot_f_out = rx_frame_reg[PSFP_SLOT_F_MSB -: 8];
    assign rx_ci_first_out = rx_frame_reg[PSFP_CI_FIRST_MSB -: 4];
    assign rx_ci_second_out = rx_frame_reg[PSFP_CI_SECOND_MSB -: 6];
    assign rx_d_out = {rx_frame_reg[PSFP_D_BIT1_POS], rx_frame_reg[PSFP_D_BIT0_POS]};
    assign rx_monitor_transmit_handshake_out = {rx_frame_reg[PSFP_MON1_TX_POS], rx_frame_reg[PSFP_MON0_TX_POS]};
    assign rx_monitor_receive_handshake_out = {rx_frame_reg[PSFP_MON1_RX_POS], rx_frame_reg[PSFP_MON0_RX_POS]};
    assign dev_serial_in_out = pin_reg;
    assign dev_serial_in_oe_out = oe_reg;
    assign locked_out = (state_reg == PSFP_LOCKED);

    // ==========================================================
    // Assertions
    // ==========================================================
    disabled_no_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !host_enable_in |=> !oe_reg) else $error("Pin driven while host disabled.");
    open_drain_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (oe_reg && iom_mode_in && $stable(iom_mode_in)) |-> !pin_reg) else $error("IOM pin driven high.");
    valid_one_cycle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rx_valid_reg |=> !rx_valid_reg) else $error("Frame valid longer than one cycle.");
    valid_at_rise_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rx_valid_reg |-> ($past(bclk_rise) && $past(idx) == $past(last_idx))) else $error("Frame closed off edge.");
    pin_on_rise_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $changed(pin_reg) |-> $past(bclk_rise)) else $error("Pin changed off bit clock edge.");
    lock_on_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (host_enable_in && bclk_rise && fs_start) |=> (locked_out && cnt_reg == 7'h01)) else $error("No lock on sync.");
    hunt_no_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!locked_out && !$past(locked_out)) |-> !oe_reg) else $error("Pin driven while hunting.");
    count_in_frame_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        cnt_reg <= PSFP_IOM_LAST) else $error("Bit counter beyond frame.");
    loss_drops_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (host_enable_in && !bclk_rise && loss_reg == LOSS_LAST) |=> (!locked_out && !oe_reg)) else $error("Lock kept.");
    legacy_drives_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (host_enable_in && bclk_rise && locked_out && !iom_mode_in) |=> oe_reg)
        else $error("Legacy pin not driven.");

endmodule

// *** psfp_host_tb.sv ***
// Self-checking bench of the peripheral serial frame port host.
`timescale 1ns/1ps
module psfp_host_tb;
    import psfp_pkg::*;
    typedef struct packed {
        logic iom;
        logic inv;
        logic [2:0] sub;
        logic [1:0] d;
        logic [95:0] dev;
        logic [95:0] host;
    } psfp_row_t;
    logic clk_in, sys_rst_in, en, iom, inv, run, idle, bclk, fs, sd, pin, oe, vld, lck;
    logic [95:0] tx, dtx, cap, rx;
    logic [1:0] d, rd, mx, mr;
    logic [2:0] sub;
    logic [7:0] b1, b2, bf;
    logic [3:0] c0;
    logic [5:0] c1;
    int n_errors, comparisons;
    psfp_row_t rows[4];
    psfp_host #(.LOSS_CYCLES(200)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .host_enable_in(en),
        .iom_mode_in(iom), .clk_invert_in(inv), .tx_frame_in(tx), .tx_d_in(d), .tx_sub_en_in(sub),
        .bit_clock_in(bclk), .frame_sync_in(fs), .dev_serial_out_in(sd), .dev_serial_in_out(pin),
        .dev_serial_in_oe_out(oe), .rx_frame_out(rx), .rx_valid_out(vld), .rx_bearer_one_out(b1),
        .rx_bearer_two_out(b2), .rx_slot_f_out(bf), .rx_ci_first_out(c0), .rx_ci_second_out(c1),
        .rx_d_out(rd), .rx_monitor_transmit_handshake_out(mx), .rx_monitor_receive_handshake_out(mr),
        .locked_out(lck));
    psfp_dev_model dev (.run_in(run), .iom_in(iom), .inv_in(inv), .idle_in(idle), .tx_in(dtx), .pin_in(pin),
        .oe_in(oe), .clk_out(bclk), .fs_out(fs), .sd_out(sd), .cap_out(cap));
    // ==========================================================
    // Helpers
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic wait_valid(input int n);
        int k;
        repeat (n) begin
            k = 0;
            cycles(1);
            while (vld !== 1'b1 && k < 4000) begin
                cycles(1);
                k++;
            end
            if (k == 4000) n_errors++;
        end
    endtask
    function automatic logic [95:0] exp_cap(input psfp_row_t r);
        logic [95:0] v;
        v = r.host;
        v[71] = r.d[0];
        v[70] = r.d[1];
        for (int k = 0; k < 3; k++) if (!r.sub[k]) v[95 - 32 * k -: 32] = 32'hffffffff;
        return v;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Clock and watchdog.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        #1500000;
        n_errors++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    initial begin
        {sys_rst_in, en, iom, inv, run, idle, d, sub} = 11'h4c0;
        {tx, dtx, n_errors, comparisons} = '0;
        rows[0] = '{1'b0, 1'b0, 3'h7, 2'h0, {24'ha5c33c, 72'h0}, {24'h5a0ff0, 72'h0}};
        rows[1] = '{1'b0, 1'b1, 3'h7, 2'h0, {24'h3c96e1, 72'h0}, {24'hc3177e, 72'h0}};
        rows[2] = '{1'b1, 1'b0, 3'h7, 2'h1, 96'hc3a51e2d96b478015aa5e10f, 96'h0f1e2d3c4b5a69788796a5b4};
        rows[3] = '{1'b1, 1'b0, 3'h1, 2'h2, 96'h5a3c81ff0e7d24c6b9e1a032, 96'h96e1c3a5781e2d4b0ff05aa5};
        repeat (12) @(posedge clk_in);
        #2 sys_rst_in = 1'b0;
        foreach (rows[i]) begin
            en = 1'b0;
            cycles(2);
            {iom, inv, sub, d, dtx, tx} = {rows[i].iom, rows[i].inv, rows[i].sub, rows[i].d, rows[i].dev, rows[i].host};
            en = 1'b1;
            // Each row stands for three frames, so command fields stay stable for more than two frames.
            wait_valid(3);
            if (iom) begin
                check(rx, dtx);
                check(96'(rx[63:48]), 96'(dtx[63:48]));
                check(96'(c0), 96'(dtx[69:66]));
                check(96'(c1), 96'(dtx[39:34]));
                check(96'(rd), 96'({dtx[70], dtx[71]}));
                check(96'({mx, mr}), 96'({dtx[32], dtx[64], dtx[33], dtx[65]}));
                check(cap, exp_cap(rows[i]));
            end else begin
                check(96'(rx[95:72]), 96'(dtx[95:72]));
                check(96'(cap[95:72]), 96'(tx[95:72]));
            end
            check(96'({b1, b2, bf}), 96'(dtx[95:72]));
            check(96'(lck), 96'h1);
        end
        // Idle keeps the bit clock running with the sync held low.
        idle = 1'b1;
        wait_valid(2);
        check(96'(lck), 96'h1);
        idle = 1'b0;
        // Stopped clocks drop the lock and the drive.
        run = 1'b0;
        cycles(600);
        check(96'({lck, oe}), 96'h0);
        run = 1'b1;
        wait_valid(3);
        check(96'(lck), 96'h1);
        // Disabled host stops driving.
        en = 1'b0;
        cycles(4);
        check(96'({lck, oe}), 96'h0);
        // Reset in mid-run.
        en = 1'b1;
        wait_valid(2);
        sys_rst_in = 1'b1;
        cycles(4);
        check(96'({oe, pin, vld, lck}), 96'h4);
        check(rx, 96'h0);
        sys_rst_in = 1'b0;
        // After reset the host relocks and delivers a whole, aligned frame.
        wait_valid(2);
        check(96'(lck), 96'h1);
        check(rx, dtx);
        complete_run();
    end
endmodule

// *** psfp_pkg.sv ***
// Constants and types shared by the peripheral serial frame port host.
package psfp_pkg;
    // Frame geometry in bits, counted from the frame sync start.
    localparam logic [6:0] PSFP_LEGACY_LAST = 7'h17;
    localparam logic [6:0] PSFP_IOM_LAST = 7'h5f;
    localparam logic [6:0] PSFP_FRAME_TOP = 7'h5f;
    localparam int PSFP_FRAME_W = 96;
    localparam int PSFP_SUB_LSB = 5;
    // Field positions inside the flattened frame vector, byte 0 at the top.
    localparam int PSFP_BEARER_ONE_MSB = 95;
    localparam int PSFP_BEARER_TWO_MSB = 87;
    localparam int PSFP_SLOT_F_MSB = 79;
    localparam int PSFP_D_BIT0_POS = 71;
    localparam int PSFP_D_BIT1_POS = 70;
    localparam int PSFP_CI_FIRST_MSB = 69;
    localparam int PSFP_MON0_RX_POS = 65;
    localparam int PSFP_MON0_TX_POS = 64;
    localparam int PSFP_CI_SECOND_MSB = 39;
    localparam int PSFP_MON1_RX_POS = 33;
    localparam int PSFP_MON1_TX_POS = 32;
    // Loss of bit clock timeout.
    localparam int PSFP_CLK_PERIOD_NS = 25;
    localparam int PSFP_LOSS_TIME_NS = 250000;
    localparam int PSFP_LOSS_CYCLES = (PSFP_LOSS_TIME_NS + PSFP_CLK_PERIOD_NS - 1) / PSFP_CLK_PERIOD_NS;
    localparam int PSFP_LOSS_W = 14;
    // Framing state of the host.
    typedef enum logic [0:0] {
        PSFP_HUNT = 1'b0,
        PSFP_LOCKED = 1'b1
    } psfp_state_t;
endpackage
